// [hdl/cmd_defs.svh]
// register map, command codes, sense codes and reset values of the command handler
`ifndef CMD_DEFS_SVH
`define CMD_DEFS_SVH

`define ADDR_W 8
`define A_CDB0 8'h00
`define A_CDB1 8'h04
`define A_CDB2 8'h08
`define A_CDB3 8'h0C
`define A_CTRL 8'h10
`define A_STATUS 8'h14
`define A_STATE 8'h18
`define A_TCFG 8'h1C

`define CTRL_GO 0
`define CTRL_LU_RESET 1

`define OP_TUR 8'h00
`define OP_REQ_SENSE 8'h03
`define OP_INQUIRY 8'h12
`define OP_SSU 8'h1B
`define OP_SYNC10 8'h35
`define OP_SYNC16 8'h91

`define PCF_START 4'h0
`define PCF_ACTIVE 4'h1
`define PCF_IDLE 4'h2
`define PCF_STBY 4'h3
`define PCF_HAND_BACK 4'h7
`define PCF_FORCE_IDLE 4'hA
`define PCF_FORCE_STBY 4'hB
`define PCF_FORCE_OFS 4'h8

`define SSU_IMMED_BIT 0
`define SYNC_IMMED_BIT 1
`define SSU_START_BIT 0

`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define SK_NONE 4'h0
`define SK_NOT_READY 4'h2
`define SK_ILLEGAL 4'h5
`define ASC_NONE 8'h00
`define ASC_NOT_READY 8'h04
`define ASCQ_CAUSE_NA 8'h00
`define ASCQ_BECOMING 8'h01
`define ASC_INV_OPCODE 8'h20
`define ASC_INV_FIELD 8'h24

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define TCFG_RST 10'h000
`define N_TIMERS 5

`endif

// [hdl/cmd_pkg.sv]
// types shared by the command handler
package cmd_pkg;
	typedef enum logic [2:0] {
		PC_ACTIVE = 3'b000,
		PC_IDLE_A = 3'b001,
		PC_IDLE_B = 3'b010,
		PC_IDLE_C = 3'b011,
		PC_STBY_Z = 3'b100,
		PC_STBY_Y = 3'b101
	} power_cond_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_EXEC = 3'b001,
		S_WAIT_MOTOR = 3'b010,
		S_WAIT_FLUSH = 3'b011,
		S_DONE = 3'b100
	} fsm_t;

	typedef struct packed {
		logic [7:0] status;
		logic [3:0] key;
		logic [7:0] asc;
		logic [7:0] ascq;
	} sense_t;

	typedef struct packed {
		logic req;
		logic to_end;
		logic [63:0] lba;
		logic [31:0] blocks;
	} flush_t;

	typedef struct packed {
		logic motor_on;
		power_cond_t pc;
		logic unit_ctl;
		logic idle_run;
		logic stby_run;
		logic restart;
		logic [4:0] force_zero;
	} power_t;
endpackage

// [hdl/cmd_handler.sv]
// spin control, cache flush and readiness command handler behind an AXI4-Lite port
`timescale 1ns/1ps
`include "cmd_defs.svh"

// How it works
// - decode power condition field and modifier
// - nonzero power condition ignores start bit
// - spin control immediate bit returns good status at once
// - explicit condition moves unit there
// - explicit condition disables timers until hand-back or logical unit reset
// - no floor or unload limit under initiator
// - hand-back starts supported enabled idle timers
// - hand-back enables idle, disables standby timer
// - force zeroes timer, enters condition, hands back
// - force on inactive timer is illegal request
// - entering current condition is no error
// - after ready, spin control always accepted
// - flush writes cached range to media
// - flush status waits for flush completion
// - flush with immediate bit is rejected
// - range from address, zero count means end
// - readiness query checks spindle speed
// - readiness query runs no diagnostics
// - immediate spin-up completes early, initiator polls
// - spindle spins up at power-on unprompted
// - before power-on done, only three commands
module cmd_handler (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic motor_at_speed,
	input wire logic flush_done,
	output cmd_pkg::power_t power,
	output cmd_pkg::flush_t flush
);
	import cmd_pkg::*;

	function automatic logic [7:0] cdb_byte(input logic [3:0][31:0] c, input int i);
		cdb_byte = c[i / 4][(i % 4) * 8 +: 8];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b * 8 +: 8] = d[b * 8 +: 8];
			end
		end
	endfunction

	// maps a condition code (force codes already shifted down) and modifier to a state
	function automatic logic pc_decode(input logic [3:0] cond, input logic [3:0] mod,
			output power_cond_t pc);
		pc = PC_ACTIVE;
		pc_decode = 1'b0;
		if (cond == `PCF_ACTIVE && mod == 4'h0) begin
			pc_decode = 1'b1;
		end else if (cond == `PCF_IDLE && mod <= 4'h2) begin
			pc = power_cond_t'(3'(mod) + 3'h1);
			pc_decode = 1'b1;
		end else if (cond == `PCF_STBY && mod <= 4'h1) begin
			pc = power_cond_t'(3'(mod) + 3'h4);
			pc_decode = 1'b1;
		end
	endfunction

	function automatic sense_t sense(input logic [3:0] key, input logic [7:0] asc,
			input logic [7:0] ascq);
		sense.status = (key == `SK_NONE) ? `ST_GOOD : `ST_CHECK;
		sense.key = key;
		sense.asc = asc;
		sense.ascq = ascq;
	endfunction

	// motor speed comes from the spindle controller, outside this clock
	logic speed_meta;
	logic at_speed;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			speed_meta <= 1'b0;
			at_speed <= 1'b0;
		end else begin
			speed_meta <= motor_at_speed;
			at_speed <= speed_meta;
		end
	end

	// bus slave state
	logic awready, wready, bvalid, arready, rvalid;
	logic aw_held, w_held;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, w_data;
	logic [3:0] w_strb;
	logic [`ADDR_W-1:0] aw_addr;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic next_aw_held, next_w_held;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, next_w_data;
	logic [3:0] next_w_strb;
	logic [`ADDR_W-1:0] next_aw_addr;
	logic wr_fire;

	// command core state
	fsm_t fsm, next_fsm;
	logic [3:0][31:0] cdb, next_cdb;
	sense_t sns, next_sns;
	logic done, next_done;
	logic por_done, next_por_done;
	logic want_speed, next_want_speed;
	logic [9:0] tcfg, next_tcfg;
	power_t pw, next_pw;
	flush_t fl, next_fl;

	always_comb begin
		next_awready = awready;
		next_wready = wready;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_arready = arready;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		wr_fire = 1'b0;
		if (s_axi_awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
			next_awready = 1'b0;
		end
		if (s_axi_wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
			next_wready = 1'b0;
		end
		if (aw_held && w_held && !bvalid) begin
			wr_fire = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (aw_addr > `A_TCFG || aw_addr == `A_STATUS
				|| aw_addr == `A_STATE || aw_addr[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
		if (s_axi_arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `RESP_OKAY;
			unique case (s_axi_araddr)
				`A_CDB0: next_rdata = cdb[0];
				`A_CDB1: next_rdata = cdb[1];
				`A_CDB2: next_rdata = cdb[2];
				`A_CDB3: next_rdata = cdb[3];
				`A_CTRL: next_rdata = 32'h0000_0000;
				`A_STATUS: next_rdata = {sns.ascq, sns.asc, 2'b00, done,
					fsm != S_IDLE && fsm != S_DONE, sns.key, sns.status};
				`A_STATE: next_rdata = {23'h00_0000, pw.stby_run, pw.idle_run, pw.unit_ctl,
					pw.pc, por_done, at_speed, pw.motor_on};
				`A_TCFG: next_rdata = {22'h00_0000, tcfg};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = `RESP_SLVERR;
				end
			endcase
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
		end
	end

	assign s_axi_awready = awready;
	assign s_axi_wready = wready;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = arready;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;

	// command execution
	logic [7:0] op;
	logic [3:0] cond, mod;
	logic [4:0] active_tmr;
	power_cond_t req_pc;
	logic pc_ok;
	logic go, lu_reset;
	logic [7:0] b1, b3, b4;
	logic [31:0] tcfg_w;

	always_comb begin
		next_fsm = fsm;
		next_cdb = cdb;
		next_sns = sns;
		next_done = done;
		next_por_done = por_done | at_speed;
		next_want_speed = want_speed;
		next_tcfg = tcfg;
		next_pw = pw;
		next_pw.restart = 1'b0;
		next_pw.force_zero = 5'h00;
		next_fl = fl;
		op = cdb_byte(cdb, 0);
		b1 = cdb_byte(cdb, 1);
		b3 = cdb_byte(cdb, 3);
		b4 = cdb_byte(cdb, 4);
		cond = b4[7:4];
		mod = b3[3:0];
		tcfg_w = merge({22'h00_0000, tcfg}, w_data, w_strb);
		// a timer is active when it is both supported and enabled
		active_tmr = tcfg[4:0] & tcfg[9:5];
		req_pc = PC_ACTIVE;
		pc_ok = 1'b0;
		go = wr_fire && aw_addr == `A_CTRL && w_strb[0] && w_data[`CTRL_GO];
		lu_reset = wr_fire && aw_addr == `A_CTRL && w_strb[0] && w_data[`CTRL_LU_RESET];

		if (wr_fire && fsm != S_EXEC && fsm != S_WAIT_MOTOR && fsm != S_WAIT_FLUSH) begin
			unique case (aw_addr)
				`A_CDB0: next_cdb[0] = merge(cdb[0], w_data, w_strb);
				`A_CDB1: next_cdb[1] = merge(cdb[1], w_data, w_strb);
				`A_CDB2: next_cdb[2] = merge(cdb[2], w_data, w_strb);
				`A_CDB3: next_cdb[3] = merge(cdb[3], w_data, w_strb);
				`A_TCFG: next_tcfg = tcfg_w[9:0];
				default: ;
			endcase
		end

		if (lu_reset) begin
			next_pw.unit_ctl = 1'b1;
			next_pw.idle_run = |active_tmr[2:0];
			next_pw.stby_run = |active_tmr[4:3];
			next_pw.restart = 1'b1;
		end

		unique case (fsm)
			S_IDLE, S_DONE: begin
				if (go && !lu_reset) begin
					next_fsm = S_EXEC;
					next_done = 1'b0;
				end
			end
			S_EXEC: begin
				next_fsm = S_DONE;
				next_done = 1'b1;
				next_sns = sense(`SK_NONE, `ASC_NONE, `ASCQ_CAUSE_NA);
				if (!por_done && op != `OP_TUR && op != `OP_INQUIRY && op != `OP_REQ_SENSE) begin
					next_sns = sense(`SK_NOT_READY, `ASC_NOT_READY, `ASCQ_BECOMING);
				end else if (op == `OP_TUR) begin
					// speed check only, no diagnostics are started
					if (!at_speed) begin
						next_sns = sense(`SK_NOT_READY, `ASC_NOT_READY, `ASCQ_CAUSE_NA);
					end
				end else if (op == `OP_SSU) begin
					if (cond == `PCF_START) begin
						next_pw.motor_on = b4[`SSU_START_BIT];
						next_want_speed = b4[`SSU_START_BIT];
						if (!b1[`SSU_IMMED_BIT]) begin
							next_fsm = S_WAIT_MOTOR;
							next_done = 1'b0;
						end
					end else if (cond == `PCF_HAND_BACK && mod == 4'h0) begin
						next_pw.unit_ctl = 1'b1;
						next_pw.restart = 1'b1;
						next_pw.idle_run = |active_tmr[2:0];
						next_pw.stby_run = 1'b0;
					end else if (cond == `PCF_FORCE_IDLE || cond == `PCF_FORCE_STBY) begin
						pc_ok = pc_decode(cond - `PCF_FORCE_OFS, mod, req_pc);
						if (!pc_ok || !active_tmr[3'(req_pc) - 3'h1]) begin
							next_sns = sense(`SK_ILLEGAL, `ASC_INV_FIELD, `ASCQ_CAUSE_NA);
						end else begin
							next_pw.force_zero[3'(req_pc) - 3'h1] = 1'b1;
							next_pw.pc = req_pc;
							next_pw.motor_on = req_pc < PC_STBY_Z;
							next_pw.unit_ctl = 1'b1;
						end
					end else begin
						pc_ok = pc_decode(cond, mod, req_pc);
						if (!pc_ok) begin
							next_sns = sense(`SK_ILLEGAL, `ASC_INV_FIELD, `ASCQ_CAUSE_NA);
						end else begin
							// same condition again simply re-enters it
							next_pw.pc = req_pc;
							next_pw.motor_on = req_pc < PC_STBY_Z;
							next_pw.unit_ctl = 1'b0;
							next_pw.idle_run = 1'b0;
							next_pw.stby_run = 1'b0;
						end
					end
				end else if (op == `OP_SYNC10 || op == `OP_SYNC16) begin
					if (b1[`SYNC_IMMED_BIT]) begin
						next_sns = sense(`SK_ILLEGAL, `ASC_INV_FIELD, `ASCQ_CAUSE_NA);
					end else begin
						next_fl.req = 1'b1;
						if (op == `OP_SYNC10) begin
							next_fl.lba = {32'h0000_0000, cdb_byte(cdb, 2), cdb_byte(cdb, 3),
								cdb_byte(cdb, 4), cdb_byte(cdb, 5)};
							next_fl.blocks = {16'h0000, cdb_byte(cdb, 7), cdb_byte(cdb, 8)};
						end else begin
							next_fl.lba = {cdb_byte(cdb, 2), cdb_byte(cdb, 3), cdb_byte(cdb, 4),
								cdb_byte(cdb, 5), cdb_byte(cdb, 6), cdb_byte(cdb, 7),
								cdb_byte(cdb, 8), cdb_byte(cdb, 9)};
							next_fl.blocks = {cdb_byte(cdb, 10), cdb_byte(cdb, 11),
								cdb_byte(cdb, 12), cdb_byte(cdb, 13)};
						end
						next_fl.to_end = next_fl.blocks == 32'h0000_0000;
						next_fsm = S_WAIT_FLUSH;
						next_done = 1'b0;
					end
				end else if (op != `OP_INQUIRY && op != `OP_REQ_SENSE) begin
					next_sns = sense(`SK_ILLEGAL, `ASC_INV_OPCODE, `ASCQ_CAUSE_NA);
				end
			end
			S_WAIT_MOTOR: begin
				// a stopping spindle still reads at speed, so stop waits for speed to drop
				if (at_speed == want_speed) begin
					next_fsm = S_DONE;
					next_done = 1'b1;
				end
			end
			S_WAIT_FLUSH: begin
				if (flush_done) begin
					next_fl.req = 1'b0;
					next_fsm = S_DONE;
					next_done = 1'b1;
				end
			end
			default: next_fsm = S_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fsm <= S_IDLE;
			cdb <= '0;
			sns <= '0;
			done <= 1'b0;
			por_done <= 1'b0;
			want_speed <= 1'b1;
			tcfg <= `TCFG_RST;
			pw.motor_on <= 1'b1;
			pw.pc <= PC_ACTIVE;
			pw.unit_ctl <= 1'b1;
			pw.idle_run <= 1'b0;
			pw.stby_run <= 1'b0;
			pw.restart <= 1'b0;
			pw.force_zero <= 5'h00;
			fl <= '0;
		end else begin
			fsm <= next_fsm;
			cdb <= next_cdb;
			sns <= next_sns;
			done <= next_done;
			por_done <= next_por_done;
			want_speed <= next_want_speed;
			tcfg <= next_tcfg;
			pw <= next_pw;
			fl <= next_fl;
		end
	end

	assign power = pw;
	assign flush = fl;
endmodule // cmd_handler

// [sim/cmd_handler_chk.sv]
// concurrent checks on the command handler ports
`timescale 1ns/1ps
module cmd_handler_chk
	import cmd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic flush_done,
	input wire cmd_pkg::power_t power,
	input wire cmd_pkg::flush_t flush
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence aw_w_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence flush_issue;
		$rose(flush.req);
	endsequence

	write_answer_a: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	flush_hold_a: assert property (flush.req && !flush_done |=>
		flush.req && $stable(flush.lba))
		else $error("flush request left before completion");
	flush_end_a: assert property (flush.req && flush_done |=> !flush.req)
		else $error("flush request held after completion");
	flush_range_a: assert property (flush_issue |-> flush.to_end == (flush.blocks == 32'h0))
		else $error("flush range end flag wrong");
	force_ctl_a: assert property (|power.force_zero |-> ##[0:1] power.unit_ctl)
		else $error("forced timer without unit control");
	force_pulse_a: assert property (|power.force_zero |=> power.force_zero == 5'h00)
		else $error("force pulse longer than one cycle");
	restart_ctl_a: assert property (power.restart |-> ##[0:1] power.unit_ctl)
		else $error("timer restart without unit control");
	timers_off_a: assert property (!power.unit_ctl && !$past(power.unit_ctl) |->
		!power.idle_run && !power.stby_run)
		else $error("timer running under initiator control");
endmodule // cmd_handler_chk

// [sim/drive_model.sv]
// spindle and media model answering the command handler
`timescale 1ns/1ps
module drive_model
	import cmd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire cmd_pkg::power_t power,
	input wire cmd_pkg::flush_t flush,
	input wire logic [7:0] spin_delay,
	input wire logic [7:0] flush_delay,
	output logic motor_at_speed,
	output logic flush_done
);
	logic [7:0] spin_cnt;
	logic [7:0] flush_cnt;
	// speed follows the motor command only after spin_delay + 1 cycles, so slow spin-up is real
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			spin_cnt <= 8'h00;
			motor_at_speed <= 1'b0;
			flush_cnt <= 8'h00;
			flush_done <= 1'b0;
		end else begin
			if (power.motor_on != motor_at_speed) begin
				if (spin_cnt >= spin_delay) begin
					motor_at_speed <= power.motor_on;
					spin_cnt <= 8'h00;
				end else
					spin_cnt <= spin_cnt + 8'h01;
			end else
				spin_cnt <= 8'h00;
			if (flush.req && !flush_done) begin
				if (flush_cnt >= flush_delay)
					flush_done <= 1'b1;
				else
					flush_cnt <= flush_cnt + 8'h01;
			end else begin
				flush_done <= 1'b0;
				flush_cnt <= 8'h00;
			end
		end
	end
endmodule // drive_model

// [sim/power_cache_ready_cmd_handler_tb.sv]
// self-checking bench for the command handler
`timescale 1ns/1ps
`include "cmd_defs.svh"
module power_cache_ready_cmd_handler_tb;
	import cmd_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic motor_at_speed, flush_done, fprev;
	logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, good, ill, nrdy, bec, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] spin_delay, flush_delay;
	power_t power;
	flush_t flush;
	int n_fail, n_tests, i;
	logic [33:0] eq[$];
	logic [33:0] mq[$];
	logic [96:0] fq[$];
	logic [3:0] tp[7] = '{4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h1};
	logic [3:0] tm[7] = '{4'h0, 4'h1, 4'h1, 4'h0, 4'h1, 4'h2, 4'h0};

	cmd_handler i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .motor_at_speed, .flush_done, .power, .flush);
	drive_model i_drv (.aclk, .aresetn, .power, .flush, .spin_delay, .flush_delay,
		.motor_at_speed, .flush_done);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task conclude;
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task tmo;
		n_fail++;
		conclude;
	endtask

	task check(input logic [127:0] got, input logic [127:0] exp, input logic [127:0] mask);
		if (mask == '0)
			return;
		n_tests++;
		if ((got & mask) !== (exp & mask)) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got & mask, exp & mask);
		end
	endtask

	// results are compared where they appear, in the order the driver noted them
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready)
			check({s_axi_bresp, 32'h0}, eq.pop_front(), mq.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			check({s_axi_rresp, s_axi_rdata}, eq.pop_front(), mq.pop_front());
		if (flush.req && !fprev)
			check({flush.to_end, flush.lba, flush.blocks}, fq.pop_front(), {97{1'b1}});
		fprev <= flush.req;
	end

	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] resp);
		int k;
		eq.push_back({resp, 32'h0});
		mq.push_back({2'b11, 32'h0});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 1000; k++) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		if (k == 1000)
			tmo;
	endtask

	task rd(input logic [7:0] a, input logic [33:0] exp, input logic [33:0] mask,
		output logic [31:0] v);
		int k;
		eq.push_back(exp);
		mq.push_back(mask);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 1000; k++) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		v = s_axi_rdata;
		s_axi_rready <= 1'b0;
		if (k == 1000)
			tmo;
	endtask

	function automatic logic [31:0] sts(logic [7:0] st, logic [3:0] key, logic [7:0] asc,
		logic [7:0] ascq);
		return {ascq, asc, 2'b00, 1'b1, 1'b0, key, st};
	endfunction

	function automatic logic [127:0] ssu(logic immed, logic start, logic [3:0] pcf,
		logic [3:0] md);
		// media load/eject bit (bit 33) stays 0
		return {88'h0, pcf, 3'b000, start, 4'h0, md, 8'h00, 7'h00, immed, `OP_SSU};
	endfunction

	// issue one command and wait for its status under a bounded poll
	task cmd(input logic [127:0] cdb, input logic [31:0] exp, input logic [31:0] mask,
		input logic mid, output logic [31:0] got);
		int k;
		logic [31:0] v;
		for (k = 0; k < 4; k++)
			wr(8'(k * 4), cdb[32 * k +: 32], `RESP_OKAY);
		wr(`A_CTRL, 32'h1, `RESP_OKAY);
		if (mid)
			rd(`A_STATUS, 34'h1000, 34'h3000, v);
		for (k = 0; k < 1000; k++) begin
			rd(`A_STATUS, 34'h0, 34'h0, v);
			if (v[13] === 1'b1)
				break;
		end
		if (k == 1000)
			tmo;
		rd(`A_STATUS, {2'b00, exp}, {2'b11, mask}, got);
	endtask

	task wait_ready;
		int k;
		for (k = 0; k < 200; k++) begin
			cmd({120'h0, `OP_TUR}, 32'h0, 32'h0, 1'b0, d);
			if (d[7:0] === `ST_GOOD)
				break;
		end
		if (k == 200)
			tmo;
	endtask

	task flush_cmd(input logic immed, input logic big, input logic [63:0] lba,
		input logic [31:0] n, input logic mid);
		logic [127:0] c;
		logic [31:0] cnt;
		c = '0;
		c[7:0] = big ? `OP_SYNC16 : `OP_SYNC10;
		c[9] = immed;
		cnt = big ? n : {16'h0, n[15:0]};
		for (int j = 0; j < 8; j++)
			c[8 * (2 + j) +: 8] = big ? lba[8 * (7 - j) +: 8] : 8'h00;
		for (int j = 0; j < 4; j++) begin
			if (big)
				c[8 * (10 + j) +: 8] = n[8 * (3 - j) +: 8];
			else
				c[8 * (2 + j) +: 8] = lba[8 * (3 - j) +: 8];
		end
		if (!big)
			c[71:56] = {n[7:0], n[15:8]};
		if (!immed)
			fq.push_back({cnt == 32'h0, big ? lba : {32'h0, lba[31:0]}, cnt});
		cmd(c, immed ? ill : good, 32'hFFFF_FFFF, mid, d);
	endtask

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		// first spin-up must outlast the opening commands so the early ready query sees slow
		spin_delay = 8'd200;
		flush_delay = 8'd0;
		fprev = 1'b0;
		aresetn = 1'b0;
		n_fail = 0;
		n_tests = 0;
		d = $urandom(32'h6303);
		good = sts(`ST_GOOD, `SK_NONE, `ASC_NONE, `ASCQ_CAUSE_NA);
		ill = sts(`ST_CHECK, `SK_ILLEGAL, `ASC_INV_FIELD, `ASCQ_CAUSE_NA);
		nrdy = sts(`ST_CHECK, `SK_NOT_READY, `ASC_NOT_READY, `ASCQ_CAUSE_NA);
		bec = sts(`ST_CHECK, `SK_NOT_READY, `ASC_NOT_READY, `ASCQ_BECOMING);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`A_TCFG, 34'h0, {34{1'b1}}, d);
		rd(8'h20, {`RESP_SLVERR, 32'h0}, {34{1'b1}}, d);
		wr(`A_STATUS, 32'h0, `RESP_SLVERR);
		cmd({120'h0, `OP_SYNC10}, bec, 32'hFFFF_FFFF, 1'b0, d);
		cmd(ssu(1'b0, 1'b1, 4'h0, 4'h0), bec, 32'hFFFF_FFFF, 1'b0, d);
		cmd({120'h0, `OP_INQUIRY}, good, 32'hFFFF_FFFF, 1'b0, d);
		cmd({120'h0, `OP_TUR}, nrdy, 32'hFFFF_FFFF, 1'b0, d);
		wait_ready;
		cmd({120'h0, `OP_TUR}, good, 32'hFFFF_FFFF, 1'b0, d);
		spin_delay <= 8'd20;
		cmd(ssu(1'b0, 1'b0, 4'h0, 4'h0), good, 32'hFFFF_FFFF, 1'b0, d);
		rd(`A_STATE, 34'h0, 34'h3, d);
		cmd({120'h0, `OP_TUR}, nrdy, 32'hFFFF_FFFF, 1'b0, d);
		spin_delay <= 8'd120;
		cmd(ssu(1'b1, 1'b1, 4'h0, 4'h0), good, 32'hFFFF_FFFF, 1'b0, d);
		rd(`A_STATE, 34'h1, 34'h3, d);
		wait_ready;
		for (i = 0; i < 7; i++) begin
			cmd(ssu(1'b0, 1'b0, tp[i], tm[i]), good, 32'hFFFF_FFFF, 1'b0, d);
			rd(`A_STATE, {25'h0, 1'b0, tp[i] == 4'h1 ? 3'h0 : 3'(tp[i] * 4'h3 - 4'h5 + tm[i]),
				2'b00, tp[i] != 4'h3}, 34'h1F9, d);
		end
		wr(`A_TCFG, 32'h3FF, `RESP_OKAY);
		cmd(ssu(1'b0, 1'b0, `PCF_HAND_BACK, 4'h1), ill, 32'hFFFF_FFFF, 1'b0, d);
		cmd(ssu(1'b0, 1'b0, `PCF_HAND_BACK, 4'h0), good, 32'hFFFF_FFFF, 1'b0, d);
		rd(`A_STATE, 34'hC0, 34'h1C0, d);
		cmd(ssu(1'b0, 1'b0, `PCF_FORCE_IDLE, 4'h1), good, 32'hFFFF_FFFF, 1'b0, d);
		rd(`A_STATE, 34'h50, 34'h78, d);
		cmd(ssu(1'b0, 1'b0, `PCF_FORCE_STBY, 4'h1), good, 32'hFFFF_FFFF, 1'b0, d);
		rd(`A_STATE, 34'h68, 34'h78, d);
		cmd(ssu(1'b0, 1'b0, `PCF_ACTIVE, 4'h0), good, 32'hFFFF_FFFF, 1'b0, d);
		// idle_a stays supported but disabled, so its timer is not active
		wr(`A_TCFG, 32'h3DF, `RESP_OKAY);
		cmd(ssu(1'b0, 1'b0, `PCF_FORCE_IDLE, 4'h0), ill, 32'hFFFF_FFFF, 1'b0, d);
		wr(`A_CTRL, 32'h2, `RESP_OKAY);
		rd(`A_STATE, 34'h1C0, 34'h1C0, d);
		flush_delay <= 8'd60;
		flush_cmd(1'b0, 1'b0, 64'h0123_4567, 32'h0010, 1'b1);
		for (i = 0; i < 3; i++) begin
			flush_delay <= 8'($urandom % 8);
			flush_cmd(1'b0, 1'b1, {$urandom, $urandom}, i == 0 ? 32'h0 : $urandom, 1'b0);
		end
		flush_cmd(1'b1, 1'b0, 64'h10, 32'h1, 1'b0);
		conclude;
	end

	initial begin
		repeat (100000) @(posedge aclk);
		tmo;
	end
endmodule // power_cache_ready_cmd_handler_tb

bind cmd_handler cmd_handler_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .flush_done, .power, .flush);
